// ===== logic/tchr_pkg.sv
package tchr_pkg;
    localparam int NUM_CH    = 16;
    localparam int HALF_CH   = 8;
    localparam int FLD_W     = 2;
    localparam int ADDR_W    = 24;
    localparam int DATA_W    = 16;

    // Register byte addresses
    localparam logic [23:0] ADDR_IRQ_ENABLE = 24'h30400a;
    localparam logic [23:0] ADDR_HSQ_HIGH   = 24'h304014;
    localparam logic [23:0] ADDR_HSQ_LOW    = 24'h304016;
    localparam logic [23:0] ADDR_PRIO_HIGH  = 24'h30401c;
    localparam logic [23:0] ADDR_PRIO_LOW   = 24'h30401e;
    localparam logic [23:0] ADDR_IRQ_FLAGS  = 24'h304020;
    localparam logic [23:0] ADDR_IRQ_FLAGS1 = 24'h304021;

    localparam logic [15:0] RST_REG  = 16'h0000;
    localparam logic [1:0]  PRIO_OFF = 2'h0;
    localparam logic [1:0]  PRIO_LOW = 2'h1;
    localparam logic [1:0]  PRIO_MED = 2'h2;
    localparam logic [1:0]  PRIO_HI  = 2'h3;

    // Byte lanes of the 16-bit host bus
    localparam logic [1:0]  BE_FULL  = 2'h3;
    localparam logic [15:0] LANE_ALL = 16'hffff;
    localparam logic [15:0] LANE_HI  = 16'hff00;
    localparam logic [15:0] LANE_LO  = 16'h00ff;

    // Seven-slot scheduler frame
    localparam logic [2:0] FRAME_LAST = 3'h6;

    typedef enum logic [1:0] {
        TCHR_SLOT_HI  = 2'b00,
        TCHR_SLOT_MED = 2'b01,
        TCHR_SLOT_LOW = 2'b10
    } tchr_slot_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0]  byte_en;
        logic        wr;
        logic        rd;
    } tchr_req_t;
endpackage

// ===== logic/tchr_regs.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module tchr_regs (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset,
    // Host register port
    input  wire tchr_pkg::tchr_req_t host_req,
    output logic [15:0]              host_rdata,
    output logic                     host_err,
    // Microcode side
    input  wire logic [15:0]         flag_set,
    input  wire logic [15:0]         routine_busy,
    output logic [31:0]              host_sequence,
    output logic [15:0]              chan_enabled,
    output logic [3:0]               sched_chan,
    output logic                     sched_valid,
    // Interrupt
    output logic                     irq
);
    logic [15:0] host_sequence_high;
    logic [15:0] host_sequence_low;
    logic [15:0] channel_priority_high;
    logic [15:0] channel_priority_low;
    logic [15:0] channel_irq_enable;
    logic [15:0] channel_irq_flags;
    logic [15:0] flags_seen;
    logic [2:0]  frame_pos;
    logic [3:0]  rr_ptr;
    logic [31:0] prio_all;
    logic [15:0] next_enabled;
    logic [15:0] prio_nonzero;
    logic        full_wr;
    logic        flag_acc;
    logic [15:0] lane_mask;
    logic        next_err;
    tchr_pkg::tchr_slot_t slot_class;
    logic [1:0]  want_code;
    logic [3:0]  next_chan;
    logic        next_valid;

    assign prio_all = {channel_priority_high, channel_priority_low};
    assign full_wr  = host_req.byte_en == tchr_pkg::BE_FULL;
    assign flag_acc = host_req.addr == tchr_pkg::ADDR_IRQ_FLAGS ||
                      host_req.addr == tchr_pkg::ADDR_IRQ_FLAGS1;

    // Odd address selects the low byte lane (big-endian bus)
    always_comb begin
        if (host_req.addr == tchr_pkg::ADDR_IRQ_FLAGS1) begin
            lane_mask = tchr_pkg::LANE_LO;
        end else if (full_wr) begin
            lane_mask = tchr_pkg::LANE_ALL;
        end else if (host_req.byte_en[1]) begin
            lane_mask = tchr_pkg::LANE_HI;
        end else begin
            lane_mask = tchr_pkg::LANE_LO;
        end
    end

    always_comb begin
        next_err = 1'b0;
        if ((host_req.wr || host_req.rd) && !flag_acc && !full_wr) begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_sequence_high <= tchr_pkg::RST_REG;
            host_sequence_low  <= tchr_pkg::RST_REG;
        end else if (host_req.wr && full_wr) begin
            if (host_req.addr == tchr_pkg::ADDR_HSQ_HIGH) begin
                host_sequence_high <= host_req.wdata;
            end
            if (host_req.addr == tchr_pkg::ADDR_HSQ_LOW) begin
                host_sequence_low <= host_req.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            channel_priority_high <= tchr_pkg::RST_REG;
            channel_priority_low  <= tchr_pkg::RST_REG;
        end else if (host_req.wr && full_wr) begin
            if (host_req.addr == tchr_pkg::ADDR_PRIO_HIGH) begin
                channel_priority_high <= host_req.wdata;
            end
            if (host_req.addr == tchr_pkg::ADDR_PRIO_LOW) begin
                channel_priority_low <= host_req.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            channel_irq_enable <= tchr_pkg::RST_REG;
        end else if (host_req.wr && full_wr && host_req.addr == tchr_pkg::ADDR_IRQ_ENABLE) begin
            channel_irq_enable <= host_req.wdata;
        end
    end

    // remember flags seen set by a read
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flags_seen <= tchr_pkg::RST_REG;
        end else if (host_req.rd && flag_acc) begin
            flags_seen <= (flags_seen & ~lane_mask) | (channel_irq_flags & lane_mask);
        end
    end

    // microcode sets flags, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            channel_irq_flags <= tchr_pkg::RST_REG;
        end else if (host_req.wr && flag_acc) begin
            channel_irq_flags <= (channel_irq_flags & ~(lane_mask & ~host_req.wdata & flags_seen)) | flag_set;
        end else begin
            channel_irq_flags <= channel_irq_flags | flag_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(channel_irq_flags & channel_irq_enable);
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_rdata <= tchr_pkg::RST_REG;
            host_err   <= 1'b0;
        end else begin
            host_rdata <= tchr_pkg::RST_REG;
            host_err   <= next_err;
            if (host_req.rd && !next_err) begin
                case (host_req.addr)
                    tchr_pkg::ADDR_IRQ_ENABLE: host_rdata <= channel_irq_enable;
                    tchr_pkg::ADDR_HSQ_HIGH:   host_rdata <= host_sequence_high;
                    tchr_pkg::ADDR_HSQ_LOW:    host_rdata <= host_sequence_low;
                    tchr_pkg::ADDR_PRIO_HIGH:  host_rdata <= channel_priority_high;
                    tchr_pkg::ADDR_PRIO_LOW:   host_rdata <= channel_priority_low;
                    tchr_pkg::ADDR_IRQ_FLAGS:  host_rdata <= channel_irq_flags & lane_mask;
                    tchr_pkg::ADDR_IRQ_FLAGS1: host_rdata <= channel_irq_flags & lane_mask;
                    default:                   host_rdata <= tchr_pkg::RST_REG;
                endcase
            end
        end
    end

    always_comb begin
        for (int i = 0; i < tchr_pkg::NUM_CH; i++) begin
            prio_nonzero[i] = prio_all[2*i +: 2] != tchr_pkg::PRIO_OFF;
            next_enabled[i] = prio_nonzero[i] || (chan_enabled[i] && routine_busy[i]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            chan_enabled  <= tchr_pkg::RST_REG;
            host_sequence <= 32'h00000000;
        end else begin
            chan_enabled  <= next_enabled;
            host_sequence <= {host_sequence_high, host_sequence_low};
        end
    end

    // slot class within frame of seven
    always_comb begin
        case (frame_pos)
            3'h0, 3'h2, 3'h4, 3'h6: slot_class = tchr_pkg::TCHR_SLOT_HI;
            3'h1, 3'h5:             slot_class = tchr_pkg::TCHR_SLOT_MED;
            3'h3:                   slot_class = tchr_pkg::TCHR_SLOT_LOW;
            default:                slot_class = tchr_pkg::TCHR_SLOT_HI;
        endcase
    end

    always_comb begin
        case (slot_class)
            tchr_pkg::TCHR_SLOT_HI:  want_code = tchr_pkg::PRIO_HI;
            tchr_pkg::TCHR_SLOT_MED: want_code = tchr_pkg::PRIO_MED;
            tchr_pkg::TCHR_SLOT_LOW: want_code = tchr_pkg::PRIO_LOW;
            default:                 want_code = tchr_pkg::PRIO_HI;
        endcase
    end

    // Round robin within the class; disabled channels never chosen
    always_comb begin
        logic [3:0] idx;
        idx        = 4'h0;
        next_chan  = 4'h0;
        next_valid = 1'b0;
        for (int k = tchr_pkg::NUM_CH - 1; k >= 0; k--) begin
            idx = rr_ptr + 4'(k);
            if (prio_all[2*idx +: 2] == want_code) begin
                next_chan  = idx;
                next_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            frame_pos   <= 3'h0;
            rr_ptr      <= 4'h0;
            sched_chan  <= 4'h0;
            sched_valid <= 1'b0;
        end else begin
            frame_pos   <= (frame_pos == tchr_pkg::FRAME_LAST) ? 3'h0 : frame_pos + 3'h1;
            sched_chan  <= next_chan;
            sched_valid <= next_valid;
            if (next_valid) begin
                rr_ptr <= next_chan + 4'h1;
            end
        end
    end

    chk_irq_follows: assert property (@(posedge ref_clk) disable iff (reset)
        ##1 irq == |($past(channel_irq_flags) & $past(channel_irq_enable)))
        else $error("irq does not match enabled flags");

    chk_prio_reset: assert property (@(posedge ref_clk)
        $fell(reset) |-> channel_priority_high == 16'h0000 && channel_priority_low == 16'h0000)
        else $error("priority not zero after reset");

    chk_flag_noread: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && flag_acc && !host_req.rd && (flags_seen & channel_irq_flags) == 16'h0000)
        |=> (channel_irq_flags & $past(channel_irq_flags)) == $past(channel_irq_flags))
        else $error("flag cleared without prior read");

    chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (reset)
        |flag_set |=> (channel_irq_flags & $past(flag_set)) == $past(flag_set))
        else $error("flag set lost");

    chk_write_one_keeps: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && flag_acc && host_req.wdata == 16'hffff)
        |=> (channel_irq_flags & $past(channel_irq_flags)) == $past(channel_irq_flags))
        else $error("writing ones cleared a flag");

    chk_prio_readback: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && full_wr && host_req.addr == tchr_pkg::ADDR_PRIO_LOW) ##1 !host_req.wr ##1
        (host_req.rd && full_wr && host_req.addr == tchr_pkg::ADDR_PRIO_LOW && !host_req.wr)
        |=> host_rdata == $past(host_req.wdata, 3))
        else $error("priority readback mismatch");

    chk_sched_class: assert property (@(posedge ref_clk) disable iff (reset)
        sched_valid |-> prio_all[2*sched_chan +: 2] != tchr_pkg::PRIO_OFF || $changed(prio_all))
        else $error("disabled channel scheduled");

    chk_byte_error: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && !full_wr && host_req.addr == tchr_pkg::ADDR_HSQ_LOW) |=> host_err && $stable(host_sequence_low))
        else $error("byte write accepted on word register");

    chk_busy_hold: assert property (@(posedge ref_clk) disable iff (reset)
        (chan_enabled & routine_busy) != 16'h0000
        |=> (chan_enabled & $past(chan_enabled & routine_busy)) == $past(chan_enabled & routine_busy))
        else $error("channel stopped during routine");

    chk_seq_low_write: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && full_wr && host_req.addr == tchr_pkg::ADDR_HSQ_LOW) |=> host_sequence_low == $past(host_req.wdata))
        else $error("low sequence write lost");

    chk_seq_high_write: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && full_wr && host_req.addr == tchr_pkg::ADDR_HSQ_HIGH) |=> host_sequence_high == $past(host_req.wdata))
        else $error("high sequence write lost");

    chk_prio_low_write: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && full_wr && host_req.addr == tchr_pkg::ADDR_PRIO_LOW) |=> channel_priority_low == $past(host_req.wdata))
        else $error("low priority write lost");

    chk_prio_high_write: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && full_wr && host_req.addr == tchr_pkg::ADDR_PRIO_HIGH) |=> channel_priority_high == $past(host_req.wdata))
        else $error("high priority write lost");

    chk_enable_write: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && full_wr && host_req.addr == tchr_pkg::ADDR_IRQ_ENABLE) |=> channel_irq_enable == $past(host_req.wdata))
        else $error("interrupt enable write lost");

    chk_enable_byte_drop: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && !full_wr && host_req.addr == tchr_pkg::ADDR_IRQ_ENABLE) |=> host_err && $stable(channel_irq_enable))
        else $error("byte write accepted on enable register");

    chk_seq_high_byte: assert property (@(posedge ref_clk) disable iff (reset)
        (host_req.wr && !full_wr && host_req.addr == tchr_pkg::ADDR_HSQ_HIGH) |=> host_err && $stable(host_sequence_high))
        else $error("byte write accepted on sequence register");

    chk_flag_byte_ok: assert property (@(posedge ref_clk) disable iff (reset)
        ((host_req.wr || host_req.rd) && flag_acc) |=> !host_err)
        else $error("status access flagged as error");

    chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset)
        !host_req.rd |=> host_rdata == 16'h0000)
        else $error("read data not zero outside read");

    chk_enable_on: assert property (@(posedge ref_clk) disable iff (reset)
        ##1 (chan_enabled & $past(prio_nonzero)) == $past(prio_nonzero))
        else $error("prioritised channel not enabled");

    chk_disable_idle: assert property (@(posedge ref_clk) disable iff (reset)
        ##1 (chan_enabled & $past(~prio_nonzero & ~routine_busy)) == 16'h0000)
        else $error("idle disabled channel still enabled");

    chk_irq_masked: assert property (@(posedge ref_clk) disable iff (reset)
        (channel_irq_flags & channel_irq_enable) == 16'h0000 |=> !irq)
        else $error("irq raised by masked flag");

    chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (reset)
        !(host_req.wr && flag_acc) |=> (channel_irq_flags & $past(channel_irq_flags)) == $past(channel_irq_flags))
        else $error("flag dropped without status write");

    chk_sched_code: assert property (@(posedge ref_clk) disable iff (reset)
        sched_valid && $stable(prio_all) |-> prio_all[2*sched_chan +: 2] == $past(want_code))
        else $error("grant priority does not match slot");

    chk_frame_wrap: assert property (@(posedge ref_clk) disable iff (reset)
        frame_pos == tchr_pkg::FRAME_LAST |=> frame_pos == 3'h0)
        else $error("scheduler frame not seven slots");

    chk_hsq_copy: assert property (@(posedge ref_clk) disable iff (reset)
        ##1 host_sequence == $past({host_sequence_high, host_sequence_low}))
        else $error("sequence copy to microcode wrong");
endmodule

// ===== tb/tchr_micro.sv
`timescale 1ns/10ps
module tchr_micro (
    // Clock
    input  wire logic   ref_clk,
    // Microcode side
    output logic [15:0] flag_set,
    output logic [15:0] routine_busy
);
    initial begin
        flag_set = 16'h0000;
        routine_busy = 16'h0000;
    end

    task automatic pulse(input int ch);
        @(posedge ref_clk);
        flag_set <= 16'h0001 << ch;
        @(posedge ref_clk);
        flag_set <= 16'h0000;
    endtask

    task automatic set_busy(input logic [15:0] v);
        @(posedge ref_clk);
        routine_busy <= v;
    endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin num_errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb;
    logic                ref_clk;
    logic                reset;
    tchr_pkg::tchr_req_t host_req;
    logic [15:0]         host_rdata;
    logic                host_err;
    logic [15:0]         flag_set;
    logic [15:0]         routine_busy;
    logic [31:0]         host_sequence;
    logic [15:0]         chan_enabled;
    logic [3:0]          sched_chan;
    logic                sched_valid;
    logic                irq;
    int                  num_errors = 0;
    int                  checks = 0;

    tchr_regs uut (.ref_clk(ref_clk), .reset(reset), .host_req(host_req), .host_rdata(host_rdata),
        .host_err(host_err), .flag_set(flag_set), .routine_busy(routine_busy),
        .host_sequence(host_sequence), .chan_enabled(chan_enabled), .sched_chan(sched_chan),
        .sched_valid(sched_valid), .irq(irq));
    tchr_micro u_micro (.ref_clk(ref_clk), .flag_set(flag_set), .routine_busy(routine_busy));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic [1:0] be, input logic err);
        @(posedge ref_clk);
        host_req <= '{addr: a, wdata: d, byte_en: be, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        host_req.wr <= 1'b0;
        #1;
        `CHK("host_err", err, host_err)
    endtask

    task automatic rd(input logic [23:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge ref_clk);
        host_req <= '{addr: a, wdata: 16'h0000, byte_en: be, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        host_req.rd <= 1'b0;
        #1;
        `CHK("host_rdata", d, host_rdata)
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_reset();
        rd(tchr_pkg::ADDR_PRIO_HIGH, 2'h3, 16'h0000);
        rd(tchr_pkg::ADDR_PRIO_LOW, 2'h3, 16'h0000);
        `CHK("chan_enabled", 16'h0000, chan_enabled)
        rd(24'h304030, 2'h3, 16'h0000);
    endtask

    task automatic t_seq();
        wr(tchr_pkg::ADDR_HSQ_LOW, 16'h00e4, 2'h3, 1'b0);
        wr(tchr_pkg::ADDR_HSQ_HIGH, 16'h0300, 2'h3, 1'b0);
        wr(tchr_pkg::ADDR_HSQ_HIGH, 16'hffff, 2'h1, 1'b1);
        wr(tchr_pkg::ADDR_HSQ_LOW, 16'hffff, 2'h2, 1'b1);
        rd(tchr_pkg::ADDR_HSQ_LOW, 2'h3, 16'h00e4);
        rd(tchr_pkg::ADDR_HSQ_HIGH, 2'h3, 16'h0300);
        `CHK("host_sequence", 32'h030000e4, host_sequence)
    endtask

    task automatic t_prio();
        int cnt[16];
        wr(tchr_pkg::ADDR_PRIO_LOW, 16'h002d, 2'h3, 1'b0);
        rd(tchr_pkg::ADDR_PRIO_LOW, 2'h3, 16'h002d);
        wait_cyc(3);
        `CHK("chan_enabled", 16'h0007, chan_enabled)
        // Any 14 slots span two whole frames
        for (int i = 0; i < 14; i++) begin
            wait_cyc(1);
            if (sched_valid === 1'b1) cnt[sched_chan]++;
        end
        `CHK("slots high", 8, cnt[1])
        `CHK("slots medium", 4, cnt[2])
        `CHK("slots low", 2, cnt[0])
        wr(tchr_pkg::ADDR_PRIO_HIGH, 16'hc000, 2'h3, 1'b0);
        rd(tchr_pkg::ADDR_PRIO_HIGH, 2'h3, 16'hc000);
        wait_cyc(2);
        `CHK("chan_enabled", 16'h8007, chan_enabled)
        wr(tchr_pkg::ADDR_PRIO_HIGH, 16'h0000, 2'h3, 1'b0);
    endtask

    task automatic t_defer();
        u_micro.set_busy(16'h0002);
        wr(tchr_pkg::ADDR_PRIO_LOW, 16'h0021, 2'h3, 1'b0);
        wait_cyc(5);
        `CHK("busy chan kept", 1'b1, chan_enabled[1])
        u_micro.set_busy(16'h0000);
        wait_cyc(3);
        `CHK("chan_enabled", 16'h0005, chan_enabled)
    endtask

    task automatic t_irq();
        wr(tchr_pkg::ADDR_IRQ_ENABLE, 16'h0008, 2'h3, 1'b0);
        rd(tchr_pkg::ADDR_IRQ_ENABLE, 2'h3, 16'h0008);
        wr(tchr_pkg::ADDR_IRQ_ENABLE, 16'hffff, 2'h2, 1'b1);
        rd(tchr_pkg::ADDR_IRQ_ENABLE, 2'h3, 16'h0008);
        u_micro.pulse(5);
        wait_cyc(3);
        `CHK("irq masked", 1'b0, irq)
        u_micro.pulse(3);
        wait_cyc(3);
        `CHK("irq", 1'b1, irq)
        // Zero write with no read first must not clear
        wr(tchr_pkg::ADDR_IRQ_FLAGS, 16'h0000, 2'h3, 1'b0);
        rd(tchr_pkg::ADDR_IRQ_FLAGS, 2'h3, 16'h0028);
        wr(tchr_pkg::ADDR_IRQ_FLAGS, 16'hfff7, 2'h3, 1'b0);
        rd(tchr_pkg::ADDR_IRQ_FLAGS, 2'h3, 16'h0020);
        wait_cyc(2);
        `CHK("irq", 1'b0, irq)
        wr(tchr_pkg::ADDR_IRQ_FLAGS1, 16'hffdf, 2'h1, 1'b0);
        rd(tchr_pkg::ADDR_IRQ_FLAGS, 2'h3, 16'h0000);
        u_micro.pulse(9);
        wait_cyc(2);
        rd(tchr_pkg::ADDR_IRQ_FLAGS, 2'h2, 16'h0200);
        wr(tchr_pkg::ADDR_IRQ_FLAGS, 16'hfdff, 2'h2, 1'b0);
        rd(tchr_pkg::ADDR_IRQ_FLAGS, 2'h3, 16'h0000);
    endtask

    initial begin
        host_req = '0;
        reset = 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_seq();
        t_prio();
        t_defer();
        t_irq();
        end_of_test();
    end

    // Whole run takes about 100 cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        end_of_test();
    end
endmodule
